// ### hw/tafdc_cfg.svh
// Purpose: Offsets, field positions and reset values of the alternate-frame config bank
// Assumes: Wishbone byte address = register offset times four
// Notes: Offsets are register indices
`ifndef TAFDC_CFG_SVH
`define TAFDC_CFG_SVH
`define TAFDC_ALT_IDX 8'hfb
`define TAFDC_OUT_IDX 8'hfe
`define TAFDC_ALT_RESET 24'h01e008
`define TAFDC_OUT_RESET 24'h21090f
`define TAFDC_ALT_FIXED_MASK 24'hfff000
`define TAFDC_ALT_FIXED_VAL 24'h01e000
`define TAFDC_OUT_FIXED_MASK 24'hffffdf
`define TAFDC_OUT_FIXED_VAL 24'h21090f
`define TAFDC_DEALIAS_BIT 11
`define TAFDC_RATIO_LSB 8
`define TAFDC_SUBCNT_LSB 1
`define TAFDC_ALTEN_BIT 0
`define TAFDC_STATS_BIT 5
`endif

// ### hw/tafdc_pkg.sv
// Purpose: Types for the alternate-frame config bank
// Assumes: Constants live in tafdc_cfg.svh
// Notes: None
package tafdc_pkg;
    typedef struct packed {
        logic alternate_frame_enable;
        logic [6:0] alternate_freq_ratio;
        logic [6:0] supplementary_subframe_count;
        logic dealias_enable;
        logic statistics_enable;
        logic frame_is_alternate;
    } tafdc_ctrl_s;
endpackage

// ### hw/tafdc_top.sv
// Purpose: Register bank that sets up alternate frames, de-aliasing and output statistics
// Assumes: Classic Wishbone slave, 32-bit data, one clock
//          Inputs are synchronous to clk_sys; frame_start is one cycle per frame
//          Software need not keep the fixed fields or the enable ordering
// Notes: Fixed fields are forced on write and read back their fixed values
//        Control word is registered and lags a register write by one cycle
//        Clock enable low freezes the bus answer, registers and frame phase
//        Unmapped word indices answer with zero data and drop writes
//        Byte lane 3 has no register bits behind it
// Function
// - Bit 11 set with bit 0 set: de-aliased depth from two successive frames
// - Bits 10-8 ratio code: 0..7 give 2,4,8,16,32,64,0,1
// - Bits 7-1 give supplementary sub-frame count, reset 4
// - Bit 0 set: alternate frames with own sub-frames, duty and frequency
// - Output register bit 5 set: statistics replace per-pixel flags
`timescale 1ns/1ns
`include "tafdc_cfg.svh"
module tafdc_top
    import tafdc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frame_start,
    output tafdc_ctrl_s ctrl_o
);
    // State: two registers, bus answer, frame phase, control word
    logic [23:0] alt_reg, alt_next;
    logic [23:0] out_reg, out_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    logic phase_reg, phase_next;
    tafdc_ctrl_s ctrl_reg, ctrl_next;
    // Bus decode: word index, request, register hits and write strobes
    logic [7:0] idx;
    logic req;
    logic hit_alt;
    logic hit_out;
    logic wr_alt;
    logic wr_out;

    // Byte-lane merge of a 24-bit register
    // Lanes left unselected keep their stored bytes
    // Lane 3 is never looked at
    function automatic logic [23:0] lane_merge(input logic [23:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [23:0] r;
        r = old;
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Word-index compare, shared by both register decodes
    function automatic logic reg_hit(input logic [7:0] index,
                                     input logic [7:0] target);
        return index == target;
    endfunction

    // Forces the fixed-value fields, so a careless write cannot disturb
    // the constants that the timing generator expects there
    function automatic logic [23:0] fix_fields(input logic [23:0] value,
                                               input logic [23:0] mask,
                                               input logic [23:0] fixed);
        return (value & ~mask) | (fixed & mask);
    endfunction

    // Alternate-to-base ratio from the 3-bit code; every code is legal,
    // so the case needs no default
    function automatic logic [6:0] ratio_of(input logic [2:0] code);
        logic [6:0] r;
        unique case (code)
            3'h0: r = 7'h02;
            3'h1: r = 7'h04;
            3'h2: r = 7'h08;
            3'h3: r = 7'h10;
            3'h4: r = 7'h20;
            3'h5: r = 7'h40;
            3'h6: r = 7'h00;
            3'h7: r = 7'h01;
        endcase
        return r;
    endfunction

    // Word index of the byte address; lane bits 1:0 play no part
    assign idx = wb_adr_i[9:2];
    // A request is not taken again in the cycle its ack stands, which keeps
    // a master that drops stb with the ack from writing twice
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign hit_alt = reg_hit(idx, `TAFDC_ALT_IDX);
    assign hit_out = reg_hit(idx, `TAFDC_OUT_IDX);
    assign wr_alt = req && wb_we_i && hit_alt;
    assign wr_out = req && wb_we_i && hit_out;

    // Bus answer: ack comes one cycle after the request is taken and
    // stands for one cycle; read data is registered with it
    // Unmapped indices answer with zero so software never hangs
    always_comb begin
        ack_next = 1'b0;
        dat_next = dat_reg;
        if (req) begin
            ack_next = 1'b1;
            if (hit_alt) begin
                dat_next = {8'h0, alt_reg};
            end else if (hit_out) begin
                dat_next = {8'h0, out_reg};
            end else begin
                dat_next = 32'h0;
            end
        end
    end

    // Bus answer registers; frozen with the rest while the
    // clock enable is low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dat_reg <= 32'h0;
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            dat_reg <= dat_next;
            ack_reg <= ack_next;
        end
    end

    // Register bank: selected byte lanes merged, then the fixed fields forced
    // Lane 3 carries no register bits and is ignored
    always_comb begin
        alt_next = alt_reg;
        out_next = out_reg;
        if (wr_alt) begin
            alt_next = fix_fields(lane_merge(alt_reg, wb_dat_i, wb_sel_i),
                `TAFDC_ALT_FIXED_MASK, `TAFDC_ALT_FIXED_VAL);
        end
        if (wr_out) begin
            out_next = fix_fields(lane_merge(out_reg, wb_dat_i, wb_sel_i),
                `TAFDC_OUT_FIXED_MASK, `TAFDC_OUT_FIXED_VAL);
        end
    end

    // Register bank storage; the fixed fields reset to
    // their constants along with the rest
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            alt_reg <= `TAFDC_ALT_RESET;
            out_reg <= `TAFDC_OUT_RESET;
        end else if (clk_en) begin
            alt_reg <= alt_next;
            out_reg <= out_next;
        end
    end

    // Frame phase: flips on each frame start while alternate frames run,
    // so base and alternate frames interleave and each pair holds one of each
    // Cleared while alternate frames are off, so the first frame after
    // enabling is always an alternate frame
    always_comb begin
        phase_next = phase_reg;
        if (!alt_reg[`TAFDC_ALTEN_BIT]) begin
            phase_next = 1'b0;
        end else if (frame_start) begin
            phase_next = !phase_reg;
        end
    end

    // Frame phase register; a frame start seen while
    // the clock enable is low is lost
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= 1'b0;
        end else if (clk_en) begin
            phase_reg <= phase_next;
        end
    end

    // Control word to the timing generator and depth engine
    // Registered, so it follows a register write one cycle later
    always_comb begin
        ctrl_next.alternate_frame_enable = alt_reg[`TAFDC_ALTEN_BIT];
        ctrl_next.alternate_freq_ratio = ratio_of(alt_reg[`TAFDC_RATIO_LSB +: 3]);
        ctrl_next.supplementary_subframe_count = alt_reg[`TAFDC_SUBCNT_LSB +: 7];
        // Needs no software ordering; gated so a premature set has no effect until alternate frames are enabled
        // and de-aliasing never runs without alternate frames
        ctrl_next.dealias_enable = alt_reg[`TAFDC_DEALIAS_BIT]
            && alt_reg[`TAFDC_ALTEN_BIT];
        ctrl_next.statistics_enable = out_reg[`TAFDC_STATS_BIT];
        // Takes the next phase so the flag is registered together with the phase
        ctrl_next.frame_is_alternate = phase_next;
    end

    // Control word register; all fields clear while in reset
    // and come up from the reset registers one edge after release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= '0;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign ctrl_o = ctrl_reg;
endmodule

// ### verif/tafdc_asserts.sv
// Purpose: port assertions of the config bank
// Assumes: one clock. Notes: bound at foot
`timescale 1ns/1ns
module tafdc_chk import tafdc_pkg::*; (
    input logic clk_sys,
    input logic resetn,
    input logic clk_en,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic wb_ack_o,
    input logic [9:0] wb_adr_i,
    input logic [31:0] wb_dat_o,
    input tafdc_ctrl_s ctrl_o
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire rda = wb_ack_o && !wb_we_i;
    ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("no ack");
    ack_one_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack held");
    top_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00) else $error("top");
    alt_fix_a: assert property (rda && wb_adr_i == 10'h3ec |-> wb_dat_o[23:12] == 12'h01e)
        else $error("alt fixed");
    out_fix_a: assert property (rda && wb_adr_i == 10'h3f8 |->
        (wb_dat_o & 32'h00ffffdf) == 32'h0021090f) else $error("out fixed");
    dealias_on_a: assert property (ctrl_o.dealias_enable |->
        ctrl_o.alternate_frame_enable) else $error("dealias");
    ratio_set_a: assert property ($onehot0(ctrl_o.alternate_freq_ratio))
        else $error("ratio");
    alt_idle_a: assert property (!ctrl_o.alternate_frame_enable |->
        !ctrl_o.frame_is_alternate) else $error("alt frame");
    cover property (rda);
    cover property (ctrl_o.dealias_enable);
    cover property (ctrl_o.statistics_enable);
    cover property (ctrl_o.frame_is_alternate);
endmodule
bind tafdc_top tafdc_chk u_chk (.*);

// ### verif/tb_top.sv
// Purpose: bench of the config bank
// Assumes: one clock, frames pulsed by the bench. Notes: fixed stimulus
`timescale 1ns/1ns
`define CK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top import tafdc_pkg::*; ;
    logic clk_sys = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic clk_en = 1'b1, frame_start = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    tafdc_ctrl_s ctrl_o;
    int n_fail = 0, samples_checked = 0;
    always #50 clk_sys = ~clk_sys;
    tafdc_top DUT (.*, .wb_stb_i(wb_cyc_i), .wb_sel_i(4'hf));
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, e);
        @(posedge clk_sys) {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        if (!w) `CK(wb_dat_o, e)
        {wb_cyc_i, wb_we_i} <= 2'b00;
        @(negedge clk_sys);
    endtask
    task t_regs;
        bus(1'b0, 10'h3ec, 32'h0, 32'h01e008);
        `CK(ctrl_o.supplementary_subframe_count, 7'h04)
        `CK(ctrl_o.alternate_freq_ratio, 7'h02)
        `CK(ctrl_o.statistics_enable, 1'b0)
        bus(1'b0, 10'h3f8, 32'h0, 32'h21090f);
        bus(1'b1, 10'h3f8, 32'h21092f, 32'h0);
        bus(1'b0, 10'h3f8, 32'h0, 32'h21092f);
        `CK(ctrl_o.statistics_enable, 1'b1)
        $display("regs done");
    endtask
    task t_alt;
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 10'h3ec, 32'h01e009 | (c << 8), 32'h0);
            `CK(ctrl_o.alternate_freq_ratio, c < 6 ? 7'h02 << c : 7'(c == 7))
        end
        `CK(ctrl_o.alternate_frame_enable, 1'b1)
        bus(1'b1, 10'h3ec, 32'h01e041, 32'h0);
        `CK(ctrl_o.supplementary_subframe_count, 7'h20)
        bus(1'b1, 10'h3ec, 32'h01e841, 32'h0);
        bus(1'b0, 10'h3ec, 32'h0, 32'h01e841);
        `CK(ctrl_o.dealias_enable, 1'b1)
        bus(1'b1, 10'h3ec, 32'h01e808, 32'h0);
        `CK(ctrl_o.dealias_enable | ctrl_o.frame_is_alternate, 1'b0)
        $display("alt done");
    endtask
    task t_frames;
        bus(1'b1, 10'h3ec, 32'h01e009, 32'h0);
        for (int k = 1; k <= 4; k++) begin
            @(posedge clk_sys) frame_start <= 1'b1;
            @(posedge clk_sys) frame_start <= 1'b0;
            @(negedge clk_sys);
            `CK(ctrl_o.frame_is_alternate, k[0])
        end
        @(posedge clk_sys) {clk_en, frame_start} <= 2'b01;
        @(posedge clk_sys) {clk_en, frame_start} <= 2'b10;
        @(negedge clk_sys);
        `CK(ctrl_o.frame_is_alternate, 1'b0)
        @(posedge clk_sys) frame_start <= 1'b1;
        @(posedge clk_sys) frame_start <= 1'b0;
        @(negedge clk_sys);
        `CK(ctrl_o.frame_is_alternate, 1'b1)
        bus(1'b1, 10'h3ec, 32'h01e008, 32'h0);
        `CK(ctrl_o.frame_is_alternate | ctrl_o.alternate_frame_enable, 1'b0)
        $display("frames done");
    endtask
    task summarize;
        $display("%0d checks, %0d failed", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs;
        t_alt;
        t_frames;
        summarize;
    end
    initial begin
        #200000 n_fail++;
        summarize;
    end
endmodule
